// ===== src/gpio_params.svh
// What this block does
// - Direction one makes pin a driven output
// - Direction zero makes pin input, driver off
// - Input with output bit one enables pull-up
// - Pull-up off when output zero or output
// - Reset tri-states every pin without clock
// - Output with output bit one drives high
// - Output with output bit zero drives low
// - Writing one to pin input toggles output
// - Pin input read-only; data, direction read/write
// - Global pull-up disable kills all pull-ups
// - Seven locations per port, bit per pin
// - Bit set/clear touches only addressed bit
// - Alternate function leaves other pins unchanged
// - Each pin has its own pull-up control
// - Pin input passes a two-stage synchronizer
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

`define PORT_W 8
`define NPORTS 2
`define ADDR_W 8
`define PORT_IDX_BIT 5
`define OFF_OUT 3'h0
`define OFF_DIR 3'h1
`define OFF_PIN 3'h2
`define OFF_OUT_SET 3'h3
`define OFF_OUT_CLR 3'h4
`define OFF_DIR_SET 3'h5
`define OFF_DIR_CLR 3'h6
`define CTRL_ADDR 8'h40
`define CTRL_PUD_BIT 0
`define RST_OUT 8'h00
`define RST_DIR 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== src/gpio_pkg.sv
`include "gpio_params.svh"

package gpio_pkg;

    typedef logic [`PORT_W-1:0] port_t;

    typedef enum logic [1:0] {WR_IDLE = 2'b00, WR_RESP = 2'b01} wr_state_e;

    typedef struct packed {
        logic awvalid;
        logic [`ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [`ADDR_W-1:0] araddr;
        logic rready;
    } axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_s;

    typedef struct packed {
        port_t [`NPORTS-1:0] out;
        port_t [`NPORTS-1:0] dir;
        port_t [`NPORTS-1:0] sync1;
        port_t [`NPORTS-1:0] sync2;
        logic global_pullup_disable;
        logic aw_got;
        logic w_got;
        logic [`ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        wr_state_e wst;
        axi_rsp_s rsp;
    } state_s;

endpackage

// ===== src/gpio_port.sv
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "gpio_params.svh"

module gpio_port
(
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Register bus
    input wire gpio_pkg::axi_req_s axi_req,
    output wire gpio_pkg::axi_rsp_s axi_rsp,
    // Pins
    input wire gpio_pkg::port_t [`NPORTS-1:0] pin_in,
    output wire gpio_pkg::port_t [`NPORTS-1:0] pin_out,
    output wire gpio_pkg::port_t [`NPORTS-1:0] pin_oe,
    output wire gpio_pkg::port_t [`NPORTS-1:0] pullup_en,
    // Alternate function overrides
    input wire gpio_pkg::port_t [`NPORTS-1:0] alt_en,
    input wire gpio_pkg::port_t [`NPORTS-1:0] alt_oe,
    input wire gpio_pkg::port_t [`NPORTS-1:0] alt_val
);

    gpio_pkg::state_s st_r;
    gpio_pkg::state_s st_nxt;
    logic wr_commit;
    logic rd_accept;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic port_hit(input logic [`ADDR_W-1:0] a);
        port_hit = (a[7:6] == 2'h0) && (a[1:0] == 2'h0) && (a[4:2] <= `OFF_DIR_CLR);
    endfunction

    function automatic logic ctrl_hit(input logic [`ADDR_W-1:0] a);
        ctrl_hit = (a == `CTRL_ADDR);
    endfunction

    function automatic logic [31:0] rd_value(input gpio_pkg::state_s s,
                                             input logic [`ADDR_W-1:0] a);
        logic p;
        p = a[`PORT_IDX_BIT];
        rd_value = 32'h0;
        if (ctrl_hit(a))
        begin
            rd_value[`CTRL_PUD_BIT] = s.global_pullup_disable;
        end
        else if (port_hit(a))
        begin
            case (a[4:2])
                `OFF_OUT: rd_value[`PORT_W-1:0] = s.out[p];
                `OFF_DIR: rd_value[`PORT_W-1:0] = s.dir[p];
                `OFF_PIN: rd_value[`PORT_W-1:0] = s.sync2[p];
                default: rd_value = 32'h0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic p;
        logic [`PORT_W-1:0] wd;
        st_nxt = st_r;
        wr_commit = 1'b0;
        rd_accept = 1'b0;
        p = st_r.awaddr[`PORT_IDX_BIT];
        wd = st_r.wstrb[0] ? st_r.wdata[`PORT_W-1:0] : 8'h00;

        // Synchronizer on the pin level
        st_nxt.sync1 = pin_in;
        st_nxt.sync2 = st_r.sync1;

        // Address and data are taken in either order
        if (axi_req.awvalid && st_r.rsp.awready)
        begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && st_r.rsp.wready)
        begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = axi_req.wdata;
            st_nxt.wstrb = axi_req.wstrb;
        end

        case (st_r.wst)
            gpio_pkg::WR_IDLE:
            begin
                if (st_r.aw_got && st_r.w_got)
                begin
                    wr_commit = 1'b1;
                    st_nxt.aw_got = 1'b0;
                    st_nxt.w_got = 1'b0;
                    st_nxt.rsp.bvalid = 1'b1;
                    st_nxt.rsp.bresp = `RESP_SLVERR;
                    st_nxt.wst = gpio_pkg::WR_RESP;
                    if (ctrl_hit(st_r.awaddr))
                    begin
                        st_nxt.rsp.bresp = `RESP_OKAY;
                        if (st_r.wstrb[0])
                        begin
                            st_nxt.global_pullup_disable = st_r.wdata[`CTRL_PUD_BIT];
                        end
                    end
                    else if (port_hit(st_r.awaddr))
                    begin
                        st_nxt.rsp.bresp = `RESP_OKAY;
                        case (st_r.awaddr[4:2])
                            `OFF_OUT:
                            begin
                                if (st_r.wstrb[0])
                                begin
                                    st_nxt.out[p] = wd;
                                end
                            end
                            `OFF_DIR:
                            begin
                                if (st_r.wstrb[0])
                                begin
                                    st_nxt.dir[p] = wd;
                                end
                            end
                            `OFF_PIN: st_nxt.out[p] = st_r.out[p] ^ wd;
                            `OFF_OUT_SET: st_nxt.out[p] = st_r.out[p] | wd;
                            `OFF_OUT_CLR: st_nxt.out[p] = st_r.out[p] & ~wd;
                            `OFF_DIR_SET: st_nxt.dir[p] = st_r.dir[p] | wd;
                            `OFF_DIR_CLR: st_nxt.dir[p] = st_r.dir[p] & ~wd;
                            default: st_nxt.rsp.bresp = `RESP_SLVERR;
                        endcase
                    end
                end
            end
            gpio_pkg::WR_RESP:
            begin
                if (axi_req.bready)
                begin
                    st_nxt.rsp.bvalid = 1'b0;
                    st_nxt.wst = gpio_pkg::WR_IDLE;
                end
            end
            default:
            begin
                st_nxt.wst = gpio_pkg::WR_IDLE;
                st_nxt.rsp.bvalid = 1'b0;
            end
        endcase
        st_nxt.rsp.awready = (st_nxt.wst == gpio_pkg::WR_IDLE) && !st_nxt.aw_got;
        st_nxt.rsp.wready = (st_nxt.wst == gpio_pkg::WR_IDLE) && !st_nxt.w_got;

        // Read channel: one read in flight
        if (st_r.rsp.rvalid)
        begin
            if (axi_req.rready)
            begin
                st_nxt.rsp.rvalid = 1'b0;
            end
        end
        else if (axi_req.arvalid && st_r.rsp.arready)
        begin
            rd_accept = 1'b1;
            st_nxt.rsp.rvalid = 1'b1;
            st_nxt.rsp.rdata = rd_value(st_r, axi_req.araddr);
            st_nxt.rsp.rresp = (port_hit(axi_req.araddr) || ctrl_hit(axi_req.araddr))
                               ? `RESP_OKAY : `RESP_SLVERR;
        end
        st_nxt.rsp.arready = !st_nxt.rsp.rvalid;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r <= '0;
            st_r.out <= {`NPORTS{`RST_OUT}};
            st_r.dir <= {`NPORTS{`RST_DIR}};
            st_r.wst <= gpio_pkg::WR_IDLE;
        end
        else if (ce)
        begin
            st_r <= st_nxt;
        end
    end

    assign axi_rsp = st_r.rsp;

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    genvar gp;
    generate
        for (gp = 0; gp < `NPORTS; gp++)
        begin : g_port
            gpio_pkg::port_t eff_dir;
            gpio_pkg::port_t eff_out;
            gpio_pkg::port_t rst_keep;
            // Overrides only reach pins whose alternate enable is set
            assign eff_dir = (alt_en[gp] & alt_oe[gp]) | (~alt_en[gp] & st_r.dir[gp]);
            assign eff_out = (alt_en[gp] & alt_val[gp]) | (~alt_en[gp] & st_r.out[gp]);
            // Reset releases the pins at once, clock or not
            assign rst_keep = {`PORT_W{aresetn}};
            assign pin_oe[gp] = eff_dir & rst_keep;
            assign pin_out[gp] = eff_out & eff_dir & rst_keep;
            assign pullup_en[gp] = ~alt_en[gp] & ~st_r.dir[gp] & st_r.out[gp]
                                   & {`PORT_W{~st_r.global_pullup_disable}} & rst_keep;

            // ----------------------------------------------------
            // Checks per port
            // ----------------------------------------------------
            sequence s_commit_to(logic [2:0] off);
                wr_commit && ce && port_hit(st_r.awaddr) && (st_r.awaddr[4:2] == off)
                && (st_r.awaddr[`PORT_IDX_BIT] == gp);
            endsequence

            a_oe_from_dir: assert property (@(posedge aclk) disable iff (!aresetn)
                (pin_oe[gp] & ~alt_en[gp]) == (st_r.dir[gp] & ~alt_en[gp]))
                else $error("output enable does not follow direction");

            a_drive_level: assert property (@(posedge aclk) disable iff (!aresetn)
                (pin_out[gp] & pin_oe[gp] & ~alt_en[gp])
                == (st_r.out[gp] & pin_oe[gp] & ~alt_en[gp]))
                else $error("driven level differs from output bit");

            a_pullup_table: assert property (@(posedge aclk)
                disable iff (!aresetn)
                pullup_en[gp] == (~alt_en[gp] & ~st_r.dir[gp] & st_r.out[gp]
                & {`PORT_W{~st_r.global_pullup_disable}}))
                else $error("pull-up enable wrong");

            a_reset_hiz: assert property (@(posedge aclk)
                !aresetn |-> (pin_oe[gp] == 8'h00) && (pullup_en[gp] == 8'h00))
                else $error("pin driven during reset");

            a_toggle_out: assert property (@(posedge aclk) disable iff (!aresetn)
                s_commit_to(`OFF_PIN) |=> st_r.out[gp] == ($past(st_r.out[gp])
                ^ ($past(st_r.wstrb[0]) ? $past(st_r.wdata[`PORT_W-1:0]) : 8'h00)))
                else $error("pin location write did not toggle output");

            a_dir_set_bit: assert property (@(posedge aclk) disable iff (!aresetn)
                s_commit_to(`OFF_DIR_SET) |=> st_r.dir[gp] == ($past(st_r.dir[gp])
                | ($past(st_r.wstrb[0]) ? $past(st_r.wdata[`PORT_W-1:0]) : 8'h00)))
                else $error("direction set touched other bits");

            a_out_clr_bit: assert property (@(posedge aclk) disable iff (!aresetn)
                s_commit_to(`OFF_OUT_CLR) |=> st_r.out[gp] == ($past(st_r.out[gp])
                & ~($past(st_r.wstrb[0]) ? $past(st_r.wdata[`PORT_W-1:0]) : 8'h00)))
                else $error("output clear touched other bits");

            sequence s_two_enabled;
                (aresetn && ce) ##1 (aresetn && ce);
            endsequence

            a_sync_delay: assert property (@(posedge aclk) disable iff (!aresetn)
                s_two_enabled |=> st_r.sync2[gp] == $past(pin_in[gp], 2))
                else $error("pin input not two stages behind pin");

            a_out_set_bit: assert property (@(posedge aclk) disable iff (!aresetn)
                s_commit_to(`OFF_OUT_SET) |=> st_r.out[gp] == ($past(st_r.out[gp])
                | ($past(st_r.wstrb[0]) ? $past(st_r.wdata[`PORT_W-1:0]) : 8'h00)))
                else $error("output set touched other bits");

            a_dir_clr_bit: assert property (@(posedge aclk) disable iff (!aresetn)
                s_commit_to(`OFF_DIR_CLR) |=> st_r.dir[gp] == ($past(st_r.dir[gp])
                & ~($past(st_r.wstrb[0]) ? $past(st_r.wdata[`PORT_W-1:0]) : 8'h00)))
                else $error("direction clear touched other bits");

            a_out_write: assert property (@(posedge aclk) disable iff (!aresetn)
                s_commit_to(`OFF_OUT) ##0 st_r.wstrb[0]
                |=> st_r.out[gp] == $past(st_r.wdata[`PORT_W-1:0]))
                else $error("output data write lost");

            a_dir_write: assert property (@(posedge aclk) disable iff (!aresetn)
                s_commit_to(`OFF_DIR) ##0 st_r.wstrb[0]
                |=> st_r.dir[gp] == $past(st_r.wdata[`PORT_W-1:0]))
                else $error("direction write lost");

            // Writes elsewhere leave this port alone
            a_port_isolate: assert property (@(posedge aclk) disable iff (!aresetn)
                aresetn && !(wr_commit && ce && port_hit(st_r.awaddr)
                && (st_r.awaddr[`PORT_IDX_BIT] == gp))
                |=> $stable(st_r.out[gp]) && $stable(st_r.dir[gp]))
                else $error("port bits moved without a write to this port");

            a_no_pull_out: assert property (@(posedge aclk) disable iff (!aresetn)
                (pullup_en[gp] & (st_r.dir[gp] | ~st_r.out[gp])) == 8'h00)
                else $error("pull-up on for a driven or low pin");

            a_quiet_pin: assert property (@(posedge aclk) disable iff (!aresetn)
                (pin_out[gp] & ~pin_oe[gp]) == 8'h00)
                else $error("level shown on a pin that is not driven");
        end
    endgenerate

    // ------------------------------------------------------------
    // Bus checks
    // ------------------------------------------------------------
    a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_commit && ce |=> st_r.rsp.bvalid && (st_r.rsp.bresp == (($past(port_hit(st_r.awaddr))
        || $past(ctrl_hit(st_r.awaddr))) ? `RESP_OKAY : `RESP_SLVERR)))
        else $error("write response missing or wrong");

    a_read_pin: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_accept && ce && port_hit(axi_req.araddr) && (axi_req.araddr[4:2] == `OFF_PIN)
        |=> st_r.rsp.rvalid
        && (st_r.rsp.rdata[`PORT_W-1:0] == $past(st_r.sync2[axi_req.araddr[`PORT_IDX_BIT]])))
        else $error("pin location read wrong");

    a_read_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_accept && ce |=> st_r.rsp.rvalid && (st_r.rsp.rresp
        == (($past(port_hit(axi_req.araddr)) || $past(ctrl_hit(axi_req.araddr)))
        ? `RESP_OKAY : `RESP_SLVERR)))
        else $error("read response wrong");

    a_read_ready: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.rsp.rvalid && axi_req.rready && ce |=> st_r.rsp.arready && !st_r.rsp.rvalid)
        else $error("read channel not free after read data taken");

    sequence s_both_taken;
        aresetn && ce && st_r.aw_got && st_r.w_got && (st_r.wst == gpio_pkg::WR_IDLE);
    endsequence

    a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        s_both_taken |=> st_r.rsp.bvalid && !st_r.rsp.awready && !st_r.rsp.wready)
        else $error("write not answered after both halves arrived");

    a_pud_write: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_commit && ce && ctrl_hit(st_r.awaddr) && st_r.wstrb[0]
        |=> st_r.global_pullup_disable == $past(st_r.wdata[`CTRL_PUD_BIT]))
        else $error("pull-up disable write lost");

    a_pud_kills: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.global_pullup_disable |-> (pullup_en == '0))
        else $error("pull-up on while globally disabled");

    a_ce_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
        aresetn && !ce |=> $stable(st_r))
        else $error("state moved while clock enable low");

endmodule // gpio_port

`default_nettype wire

// ===== test/pin_env.sv
`timescale 1ns/100ps
`default_nettype none
`include "gpio_params.svh"

module pin_env
(
    // Clock
    input wire logic aclk,
    // Device side of the pins
    input wire gpio_pkg::port_t [`NPORTS-1:0] pin_out,
    input wire gpio_pkg::port_t [`NPORTS-1:0] pin_oe,
    input wire gpio_pkg::port_t [`NPORTS-1:0] pullup_en,
    // Outside circuit drive
    input wire gpio_pkg::port_t [`NPORTS-1:0] ext_en,
    input wire gpio_pkg::port_t [`NPORTS-1:0] ext_val,
    // Resolved pin level
    output var gpio_pkg::port_t [`NPORTS-1:0] pin_in
);
    // ----------------------------------------
    // Wire resolution
    // ----------------------------------------
    gpio_pkg::port_t [`NPORTS-1:0] float_r;

    initial float_r = '0;

    // A floating pin keeps changing so a stale level never reads as valid
    always @(posedge aclk) float_r <= ~pin_in;

    always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & pullup_en) | (~pin_oe & ~ext_en & ~pullup_en & float_r);
endmodule // pin_env

`default_nettype wire

// ===== test/general_io_port_pin_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "gpio_params.svh"

module general_io_port_pin_control_tb;
    // ----------------------------------------
    // Clock and design
    // ----------------------------------------
    logic aclk = 1'b0;
    logic aresetn;
    logic ce;
    gpio_pkg::axi_req_s req;
    wire gpio_pkg::axi_rsp_s rsp;
    wire gpio_pkg::port_t [`NPORTS-1:0] pin_in, pin_out, pin_oe, pullup_en;
    gpio_pkg::port_t [`NPORTS-1:0] alt_en, alt_oe, alt_val, ext_val, ext_en;
    gpio_pkg::port_t [`NPORTS-1:0] out_m, dir_m, eoe, eout, epu, elv, ekn;
    logic pud_m;
    int n_fail = 0;
    int check_count = 0;
    logic [31:0] rd;
    logic [31:0] v;
    logic [1:0] rr;
    int p, op, b;

    always #50 aclk = ~aclk;

    gpio_port gpio_port_i (.aclk(aclk), .aresetn(aresetn), .ce(ce), .axi_req(req),
        .axi_rsp(rsp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_en(pullup_en), .alt_en(alt_en), .alt_oe(alt_oe), .alt_val(alt_val));
    pin_env pin_env_i (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic timeout();
        n_fail++;
        results();
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic pins();
        @(negedge aclk);
        for (int i = 0; i < `NPORTS; i++)
        begin
            eoe[i] = (dir_m[i] & ~alt_en[i]) | (alt_oe[i] & alt_en[i]);
            eout[i] = ((out_m[i] & ~alt_en[i]) | (alt_val[i] & alt_en[i])) & eoe[i];
            epu[i] = ~dir_m[i] & out_m[i] & ~alt_en[i] & {8{~pud_m}};
            elv[i] = (eoe[i] & eout[i]) | (~eoe[i] & ext_en[i] & ext_val[i])
                | (~eoe[i] & ~ext_en[i] & epu[i]);
            // Pins nobody drives or pulls float and are left out
            ekn[i] = eoe[i] | ext_en[i] | epu[i];
        end
        chk({16'h0, pin_oe}, {16'h0, eoe});
        chk({16'h0, pin_out}, {16'h0, eout});
        chk({16'h0, pullup_en}, {16'h0, epu});
    endtask

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    function automatic logic [7:0] ad(input int q, input logic [2:0] o);
        return 8'(q * 32 + o * 4);
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int k = 0;
        @(posedge aclk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            k++;
            if (k > 50) timeout();
        end
        while (!rsp.bvalid);
        r = rsp.bresp;
        req.bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int k = 0;
        @(posedge aclk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (rsp.arready) req.arvalid <= 1'b0;
            k++;
            if (k > 50) timeout();
        end
        while (!rsp.rvalid);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
    endtask

    task automatic rb(input int q);
        rdr(ad(q, `OFF_OUT), rd, rr);
        chk(rd, {24'h0, out_m[q]});
        rdr(ad(q, `OFF_DIR), rd, rr);
        chk(rd, {24'h0, dir_m[q]});
        rdr(ad(q, `OFF_PIN), rd, rr);
        chk(rd & {24'h0, ekn[q]}, {24'h0, elv[q] & ekn[q]});
        rdr(`CTRL_ADDR, rd, rr);
        chk(rd, {31'h0, pud_m});
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        aresetn = 1'b0;
        ce = 1'b1;
        req = '0;
        alt_en = '0;
        alt_oe = '0;
        alt_val = '0;
        ext_val = '0;
        ext_en = '1;
        out_m = '0;
        dir_m = '0;
        pud_m = 1'b0;
        void'($urandom(71));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        pins();
        rb(0);
        rb(1);
        for (int it = 0; it < 80; it++)
        begin
            @(posedge aclk);
            p = $urandom_range(1);
            b = $urandom_range(7);
            op = $urandom_range(7);
            v = {24'h0, 8'($urandom)};
            if (op >= 3 && op <= 6) v = 32'h1 << b;
            ext_val <= 16'($urandom);
            ext_en <= 16'($urandom | $urandom);
            alt_en <= 16'($urandom & $urandom & $urandom);
            alt_oe <= 16'($urandom);
            alt_val <= 16'($urandom);
            // One location per write, so each pin passes an intermediate state
            wr(op == 7 ? `CTRL_ADDR : ad(p, 3'(op)), v, rr);
            chk({30'h0, rr}, {30'h0, `RESP_OKAY});
            case (op)
                0: out_m[p] = v[7:0];
                1: dir_m[p] = v[7:0];
                2: out_m[p] ^= v[7:0];
                3: out_m[p][b] = 1'b1;
                4: out_m[p][b] = 1'b0;
                5: dir_m[p][b] = 1'b1;
                6: dir_m[p][b] = 1'b0;
                default: pud_m = v[0];
            endcase
            pins();
            rb(p);
        end
        wr(8'h1c, 32'hff, rr);
        chk({30'h0, rr}, {30'h0, `RESP_SLVERR});
        rdr(8'h44, rd, rr);
        chk({rd[31:2], rr}, {30'h0, `RESP_SLVERR});
        pins();
        wr(ad(0, `OFF_DIR), 32'hff, rr);
        dir_m[0] = 8'hff;
        wr(ad(1, `OFF_DIR), 32'h00, rr);
        dir_m[1] = 8'h00;
        wr(ad(1, `OFF_OUT), 32'hff, rr);
        out_m[1] = 8'hff;
        wr(`CTRL_ADDR, 32'h0, rr);
        pud_m = 1'b0;
        pins();
        // Pin changes made while the enable is low stay out of the pin input
        @(posedge aclk);
        ce <= 1'b0;
        ext_val <= ~ext_val;
        repeat (4) @(posedge aclk);
        ce <= 1'b1;
        rdr(ad(1, `OFF_PIN), rd, rr);
        chk(rd & {24'h0, ekn[1]}, {24'h0, elv[1] & ekn[1]});
        pins();
        rb(1);
        @(posedge aclk);
        aresetn <= 1'b0;
        #1;
        chk({16'h0, pin_oe}, 32'h0);
        chk({16'h0, pullup_en}, 32'h0);
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        out_m = '0;
        dir_m = '0;
        pins();
        rb(0);
        rb(1);
        results();
    end
endmodule // general_io_port_pin_control_tb

`default_nettype wire
